// File: hw/fault_irq_ctrl.v
// Fault interrupt controller of an LED backlight driver, AXI4-Lite slave
// Assumes fault inputs are asynchronous levels from the analog blocks
// Notes on behaviour
// - enable reads 0h off, 2h on
// - write 1h disables, 3h enables
// - global enable bits 7-6 gate output
// - bits 5-4 enable bus timeout interrupt
// - bits 3-2 enable bad string interrupt
// - bits 1-0 enable LED fault interrupt
// - bits 15-8 reserved, read zero
// - fault bit reads 1 once seen, sticky
// - status plus clear bit together clear
// - CRC flag bit 15, clear 14
// - sync clock missing bit 13, clear 12
// - charge pump fault bit 11, clear 10
// - pump capacitor missing bit 9, clear 8
// - input overcurrent bit 7, clear 6
// - core undervoltage bit 5, clear 4
// - input overvoltage bit 3, clear 2
// - input undervoltage bit 1, clear 0
// - supply faults other than CRC gated by per-fault enables
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fault_irq_regs.vh"
module fault_irq_ctrl
(
	input wire mclk,
	input wire rstn,
	input wire [7:0] supply_fault_in, // Supply faults, bit 7 is CRC
	input wire bus_timeout_in, // Bus communication timeout
	input wire bad_string_in, // Invalid string configuration
	input wire led_fault_in, // LED open or short
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg fault_irq // Level interrupt, high while fault pending
);

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Read code of an enable field: 2h on, 0h off
function [1:0] en_code;
	input en;
	begin
		en_code = {en, 1'b0};
	end
endfunction

// Byte address of a register index
function [7:0] byte_addr;
	input [7:0] idx;
	begin
		byte_addr = {idx[5:0], 2'b00};
	end
endfunction

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [10:0] sync1; // First stage, read only by sync2
reg [10:0] sync2; // Second stage, used by logic
wire [10:0] raw_in;
assign raw_in = {led_fault_in, bad_string_in, bus_timeout_in,
	supply_fault_in};

always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		sync1 <= 11'h000;
		sync2 <= 11'h000;
	end
	else
	begin
		sync1 <= raw_in;
		sync2 <= sync1;
	end
end

// ----------------------------------------
// AXI4-Lite write channel
// ----------------------------------------
reg aw_held; // Address taken, waiting for data
reg w_held; // Data taken, waiting for address
reg [7:0] aw_addr; // Held write address
reg [31:0] w_data; // Held write data
reg [3:0] w_strb; // Held byte strobes
wire wr_go; // Both halves present, perform write
wire wr_hit; // Held address names a mapped register

// Accept each half once; stall until the response is taken
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign wr_go = aw_held && w_held;

always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (wr_go)
		begin
			// Write commits here; response the next cycle
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end
end

// ----------------------------------------
// Write decode
// ----------------------------------------
// Fields live in the low 16 bits; a field changes only when its own byte lane
// is strobed, so partial lanes only touch their own byte
wire lo_ok;
wire hi_ok;
wire wr_led_en;
wire wr_sup_en;
wire wr_flags;
wire wr_mask;
assign lo_ok = w_strb[0];
assign hi_ok = w_strb[1];
assign wr_led_en = wr_go && aw_addr == byte_addr(`LED_IRQ_EN_IDX);
assign wr_sup_en = wr_go && aw_addr == byte_addr(`SUPPLY_IRQ_EN_IDX);
assign wr_flags = wr_go && aw_addr == byte_addr(`SUPPLY_FLAGS_IDX);
assign wr_mask = wr_go && aw_addr == byte_addr(`IRQ_MASK_IDX);
assign wr_hit = wr_led_en || wr_sup_en || wr_flags || wr_mask ||
	aw_addr == byte_addr(`LED_FLAGS_IDX) ||
	aw_addr == byte_addr(`IRQ_STATUS_IDX);

// ----------------------------------------
// LED enable register: four guarded fields
// ----------------------------------------
wire [3:0] led_en; // 3 global, 2 timeout, 1 string, 0 LED fault
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1)
	begin : g_led_en
		guarded_enable u_en
		(
			.mclk(mclk),
			.rstn(rstn),
			.wr(wr_led_en && lo_ok),
			.wdata(w_data[2*gi+1:2*gi]),
			.enabled(led_en[gi])
		);
	end
endgenerate

// ----------------------------------------
// Supply enable register: seven guarded fields
// ----------------------------------------
// Index 6 sits at bits 13-12; bits 15-14 are reserved
wire [6:0] sup_en;
generate
	for (gi = 0; gi < 7; gi = gi + 1)
	begin : g_sup_en
		guarded_enable u_en
		(
			.mclk(mclk),
			.rstn(rstn),
			.wr(wr_sup_en && (gi < 4 ? lo_ok : hi_ok)),
			.wdata(w_data[2*gi+1:2*gi]),
			.enabled(sup_en[gi])
		);
	end
endgenerate

// ----------------------------------------
// Supply fault flags: status at odd bit, clear at even bit
// ----------------------------------------
// Pair k: status bit 2k+1, clear bit 2k; pair 7 is the CRC error
wire [7:0] sup_flag;
wire [7:0] sup_rise;
generate
	for (gi = 0; gi < 8; gi = gi + 1)
	begin : g_flag
		fault_flag u_flag
		(
			.mclk(mclk),
			.rstn(rstn),
			.fault_in(sync2[gi]),
			.wr(wr_flags && (gi < 4 ? lo_ok : hi_ok)),
			.wr_flag(w_data[2*gi+1]),
			.wr_clr(w_data[2*gi]),
			.flag(sup_flag[gi]),
			.rise(sup_rise[gi])
		);
	end
endgenerate

// LED-side faults, cleared through the LED flags register (status/clear
// pairs: bit 5/4 timeout, 3/2 string, 1/0 LED fault)
wire [2:0] led_flag;
wire [2:0] led_rise;
generate
	for (gi = 0; gi < 3; gi = gi + 1)
	begin : g_led_flag
		fault_flag u_flag
		(
			.mclk(mclk),
			.rstn(rstn),
			.fault_in(sync2[10-gi]),
			.wr(wr_go && lo_ok && aw_addr == byte_addr(`LED_FLAGS_IDX)),
			.wr_flag(w_data[2*gi+1]),
			.wr_clr(w_data[2*gi]),
			.flag(led_flag[gi]),
			.rise(led_rise[gi])
		);
	end
endgenerate
// led_flag[0] LED fault, [1] string, [2] timeout

// ----------------------------------------
// Interrupt pin
// ----------------------------------------
// CRC error has no enable field and always counts
wire sup_pend;
wire led_pend;
assign sup_pend = |(sup_flag[6:0] & sup_en) | sup_flag[7];
assign led_pend = (led_flag[0] & led_en[0]) |
	(led_flag[1] & led_en[1]) |
	(led_flag[2] & led_en[2]);

// ----------------------------------------
// Sticky event status and mask
// ----------------------------------------
reg [`EV_WIDTH-1:0] ev_status; // Set on new faults, cleared by read
reg [`EV_WIDTH-1:0] ev_mask; // One enables the event onto the pin
wire [`EV_WIDTH-1:0] ev_set;
wire rd_status;
assign ev_set = {led_rise[0], led_rise[1], led_rise[2], |sup_rise};

// Read clears, but a new event in the same cycle survives
always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
		ev_status <= {`EV_WIDTH{1'b0}};
	else if (rd_status)
		ev_status <= ev_set;
	else
		ev_status <= ev_status | ev_set;
end

// Mask reset value, cut to the event width on purpose
localparam [15:0] MASK_RST = `IRQ_MASK_RST;

// Mask register write
always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
		ev_mask <= MASK_RST[`EV_WIDTH-1:0];
	else if (wr_mask && lo_ok)
		ev_mask <= w_data[`EV_WIDTH-1:0];
end

// Pin: latched faults, or unmasked sticky events; global gates all
always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
		fault_irq <= 1'b0;
	else
		fault_irq <= led_en[3] && (sup_pend || led_pend ||
			|(ev_status & ev_mask));
end

// ----------------------------------------
// AXI4-Lite read channel
// ----------------------------------------
reg [31:0] next_rdata;
assign s_axi_arready = !s_axi_rvalid;
assign rd_status = s_axi_arvalid && s_axi_arready &&
	s_axi_araddr == byte_addr(`IRQ_STATUS_IDX);

// Read mux; reserved bits and upper half read zero
always @*
begin
	next_rdata = 32'h00000000;
	case (s_axi_araddr)
		byte_addr(`LED_IRQ_EN_IDX):
			next_rdata[7:0] = {en_code(led_en[3]), en_code(led_en[2]),
				en_code(led_en[1]), en_code(led_en[0])};
		byte_addr(`SUPPLY_IRQ_EN_IDX):
			next_rdata[13:0] = {en_code(sup_en[6]), en_code(sup_en[5]),
				en_code(sup_en[4]), en_code(sup_en[3]), en_code(sup_en[2]),
				en_code(sup_en[1]), en_code(sup_en[0])};
		byte_addr(`SUPPLY_FLAGS_IDX):
			next_rdata[15:0] = {sup_flag[7], 1'b0, sup_flag[6], 1'b0,
				sup_flag[5], 1'b0, sup_flag[4], 1'b0, sup_flag[3], 1'b0,
				sup_flag[2], 1'b0, sup_flag[1], 1'b0, sup_flag[0],
				1'b0};
		byte_addr(`LED_FLAGS_IDX):
			next_rdata[5:0] = {led_flag[2], 1'b0, led_flag[1], 1'b0,
				led_flag[0], 1'b0};
		byte_addr(`IRQ_STATUS_IDX):
			next_rdata[`EV_WIDTH-1:0] = ev_status;
		byte_addr(`IRQ_MASK_IDX):
			next_rdata[`EV_WIDTH-1:0] = ev_mask;
		default:
			next_rdata = 32'h00000000;
	endcase
end

// Read response one cycle after the address is taken
always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `RESP_OKAY;
	end
	else if (s_axi_arvalid && s_axi_arready)
	begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= next_rdata;
		case (s_axi_araddr)
			byte_addr(`LED_IRQ_EN_IDX), byte_addr(`SUPPLY_IRQ_EN_IDX),
			byte_addr(`SUPPLY_FLAGS_IDX), byte_addr(`LED_FLAGS_IDX),
			byte_addr(`IRQ_STATUS_IDX), byte_addr(`IRQ_MASK_IDX):
				s_axi_rresp <= `RESP_OKAY;
			default:
				s_axi_rresp <= `RESP_SLVERR;
		endcase
	end
	else if (s_axi_rvalid && s_axi_rready)
		s_axi_rvalid <= 1'b0;
end

endmodule
`default_nettype wire

// File: hw/fault_irq_regs.vh
// Register offsets, field positions, reset values for the fault interrupt block
// Assumes a 32-bit AXI4-Lite register port; all offsets below are
// register indices and the byte address is four times the index.
`ifndef FAULT_IRQ_REGS_VH
`define FAULT_IRQ_REGS_VH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define LED_IRQ_EN_IDX 8'h0c
`define SUPPLY_FLAGS_IDX 8'h0e
`define SUPPLY_IRQ_EN_IDX 8'h14
`define LED_FLAGS_IDX 8'h15
`define IRQ_STATUS_IDX 8'h16
`define IRQ_MASK_IDX 8'h17

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LED_IRQ_EN_RST 16'h00aa
`define SUPPLY_IRQ_EN_RST 16'h2aaa
`define SUPPLY_FLAGS_RST 16'h0000
`define IRQ_MASK_RST 16'h0000

// ----------------------------------------
// Field positions of the LED enable register
// ----------------------------------------
`define GLOBAL_EN_HI 7
`define TIMEOUT_EN_HI 5
`define BAD_STRING_EN_HI 3
`define LED_FAULT_EN_HI 1

// ----------------------------------------
// Event bits of the sticky status register
// ----------------------------------------
`define EV_SUPPLY 0
`define EV_TIMEOUT 1
`define EV_BAD_STRING 2
`define EV_LED_FAULT 3
`define EV_WIDTH 4

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: hw/guarded_enable.v
// One two-bit guarded interrupt enable field
// Assumes wr is a one-cycle write strobe on mclk
`timescale 1ns/1ps
`default_nettype none
module guarded_enable
(
	input wire mclk,
	input wire rstn,
	input wire wr, // Write strobe for this field
	input wire [1:0] wdata, // Written code
	output reg enabled // Current enable state
);

// ----------------------------------------
// Enable bit, resets enabled
// ----------------------------------------
// Only codes with the low bit set act; 0h and 2h change nothing.
// The upper bit is the new state, so 1h disables and 3h enables.
always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
		enabled <= 1'b1;
	else if (wr && wdata[0])
		enabled <= wdata[1];
end
endmodule
`default_nettype wire

// File: hw/fault_flag.v
// One sticky fault flag with paired status and clear write bits
// Assumes fault_in is already synchronised to mclk
`timescale 1ns/1ps
`default_nettype none
module fault_flag
(
	input wire mclk,
	input wire rstn,
	input wire fault_in, // Fault level, same domain
	input wire wr, // Write strobe to the flag register
	input wire wr_flag, // Written status bit
	input wire wr_clr, // Written clear bit
	output reg flag, // Latched fault
	output wire rise // One-cycle pulse when a new fault latches
);

reg fault_d; // Previous fault level

// ----------------------------------------
// Latch and guarded clear
// ----------------------------------------
// A fault present in the clear cycle wins, so no event is lost
always @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		flag <= 1'b0;
		fault_d <= 1'b0;
	end
	else
	begin
		fault_d <= fault_in;
		if (fault_in)
			flag <= 1'b1;
		else if (wr && wr_flag && wr_clr)
			flag <= 1'b0;
	end
end

assign rise = fault_in & ~fault_d;
endmodule
`default_nettype wire

// File: verification/fault_source.sv
// Model of the analog fault comparators feeding the block
// Assumes the bench names in want the faults it wants raised
`timescale 1ns/1ps
`default_nettype none
module fault_source
(
	input wire logic [10:0] want, // Bit 8 timeout, 9 string, 10 LED
	output wire logic [7:0] supply_fault_in,
	output wire logic bus_timeout_in,
	output wire logic bad_string_in,
	output wire logic led_fault_in
);
	// Levels move off the clock grid, as a comparator output would
	assign #7 {led_fault_in, bad_string_in, bus_timeout_in,
		supply_fault_in} = want;
endmodule
`default_nettype wire

// File: verification/fault_irq_chk.sv
// Checker for the fault interrupt controller, bound to its top module
// Assumes the AXI4-Lite slave ports and fault_irq as the design declares
`timescale 1ns/1ps
`default_nettype none
`include "fault_irq_regs.vh"
module fault_irq_chk
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_irq
);
	// ----------------------------------------
	// Read tracking and assertions
	// ----------------------------------------
	logic [7:0] last_ar; // Register the pending read answers for
	wire mapped = last_ar inside {8'h30, 8'h38, 8'h50, 8'h54, 8'h58, 8'h5c};
	// Only one read is open, so the taken address names the answer
	always @(posedge mclk or negedge rstn)
		if (!rstn)
			last_ar <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			last_ar <= s_axi_araddr;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_w_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> ##1 s_axi_bvalid;
	endproperty
	a_w_lat: assert property (p_w_lat) else $error("write answer late");
	property p_no_take;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_no_take: assert property (p_no_take) else $error("write taken early");
	property p_en_codes;
		s_axi_rvalid && last_ar == 8'h30 |-> (s_axi_rdata & 32'h55) == 32'h0;
	endproperty
	a_en_codes: assert property (p_en_codes) else $error("bad code");
	property p_rsvd;
		s_axi_rvalid && last_ar == 8'h30 |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved set");
	property p_clr_bits;
		s_axi_rvalid && last_ar == 8'h38 |-> (s_axi_rdata & 32'hffff5555) == 0;
	endproperty
	a_clr_bits: assert property (p_clr_bits) else $error("clear bit read 1");
	property p_unmapped;
		s_axi_rvalid && !mapped |-> s_axi_rresp == `RESP_SLVERR
			&& s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read ok");
	property p_irq_fall;
		$fell(fault_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
			|| $past(s_axi_rvalid) || $past(s_axi_rvalid, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
endmodule
bind fault_irq_ctrl fault_irq_chk chk (.*);
`default_nettype wire

// File: verification/fault_irq_enable_supply_fault_flags_test.sv
// Self-checking bench for the fault interrupt controller
// Assumes a 40 MHz mclk and the register map in fault_irq_regs.vh
`timescale 1ns/1ps
`default_nettype none
`include "fault_irq_regs.vh"
module fault_irq_enable_supply_fault_flags_test;
	// ----------------------------------------
	// Wiring, clock and shared tasks
	// ----------------------------------------
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [10:0] want = 11'h000; // Faults for the source model
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	wire [7:0] supply_fault_in;
	wire bus_timeout_in;
	wire bad_string_in;
	wire led_fault_in;
	wire s_axi_awready;
	wire s_axi_wready;
	wire s_axi_arready;
	wire s_axi_bvalid;
	wire s_axi_rvalid;
	wire [1:0] s_axi_bresp;
	wire [1:0] s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire fault_irq;
	int num_errors = 0;
	int samples_checked = 0;
	logic [31:0] d; // Last read data
	logic [1:0] r; // Last read response
	logic [1:0] br; // Last write response
	logic [15:0] en; // Expected enable register
	logic [15:0] w;
	int i;
	int p;
	fault_irq_ctrl dut (.*);
	fault_source src (.*);
	// Free-running 40 MHz clock
	always #12.5 mclk = ~mclk;
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// A hung handshake counts as a mismatch and ends the run
	task bail;
		num_errors++;
		report_and_stop;
	endtask
	// Both write halves go out together; each drops when taken
	task wr(input logic [7:0] a, input logic [15:0] v);
		bit done;
		done = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, v};
		s_axi_wstrb <= 4'h3;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				done = 1;
				br = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
		if (!done)
			bail;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] e);
		bit done;
		done = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				done = 1;
				q = s_axi_rdata;
				e = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
		if (!done)
			bail;
	endtask
	// Low bit of a code qualifies the write, high bit is the new state
	function logic [15:0] next_en(input logic [15:0] e, input logic [15:0] v);
		for (int k = 0; k < 4; k++)
			if (v[2 * k])
				e[2 * k + 1] = v[2 * k + 1];
		return e & 16'h00aa;
	endfunction
	initial
	begin
		void'($urandom(32'hcc8c28a7));
		wt(20);
		rstn <= 1'b1;
		rd(8'h30, d, r);
		chk(d, 32'h00aa);
		rd(8'h38, d, r);
		chk(d, 32'h0);
		rd(8'h04, d, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		wr(8'h04, 16'hffff);
		chk({30'h0, br}, {30'h0, `RESP_SLVERR});
		$display("test reset done");
		en = 16'h00aa;
		for (i = 0; i < 24; i++)
		begin
			w = (i == 0) ? 16'h5555 : (i == 1) ? 16'haaaa : 16'($urandom);
			en = next_en(en, w);
			wr(8'h30, w);
			rd(8'h30, d, r);
			chk(d, {16'h0000, en});
		end
		wr(8'h30, 16'h00ff);
		chk({30'h0, br}, {30'h0, `RESP_OKAY});
		$display("test enable codes done");
		for (i = 0; i < 8; i++)
		begin
			p = 2 * i;
			want <= 11'h001 << i;
			wt(6);
			chk(fault_irq, 1'b1);
			want <= 11'h000;
			wt(4);
			rd(8'h38, d, r);
			chk(d, 32'h2 << p);
			if (i == 7)
			begin
				wr(8'h30, 16'h0040);
				wt(2);
				chk(fault_irq, 1'b0);
				wr(8'h30, 16'h00c0);
			end
			wr(8'h38, 16'h2 << p);
			rd(8'h38, d, r);
			chk(d, 32'h2 << p);
			wr(8'h38, 16'h3 << p);
			wt(2);
			chk(fault_irq, 1'b0);
			rd(8'h38, d, r);
			chk(d, 32'h0);
		end
		wr(8'h50, 16'h0001);
		want <= 11'h001;
		wt(6);
		chk(fault_irq, 1'b0);
		want <= 11'h000;
		wr(8'h38, 16'h0003);
		wr(8'h50, 16'h0003);
		rd(8'h58, d, r);
		$display("test supply flags done");
		for (i = 0; i < 3; i++)
		begin
			p = 4 - 2 * i;
			want <= 11'h100 << i;
			wt(6);
			chk(fault_irq, 1'b1);
			want <= 11'h000;
			wr(8'h30, 16'h1 << p);
			wt(2);
			chk(fault_irq, 1'b0);
			wr(8'h54, 16'h3 << p);
			wr(8'h30, 16'h3 << p);
			wt(2);
			chk(fault_irq, 1'b0);
		end
		$display("test led flags done");
		rd(8'h58, d, r);
		chk(d, 32'he);
		wr(8'h30, 16'h0010);
		wr(8'h5c, 16'h0002);
		want <= 11'h100;
		wt(6);
		chk(fault_irq, 1'b1);
		wr(8'h5c, 16'h0000);
		wt(2);
		chk(fault_irq, 1'b0);
		rd(8'h58, d, r);
		chk(d, 32'h2);
		want <= 11'h000;
		$display("test event mask done");
		report_and_stop;
	end
endmodule
`default_nettype wire
